// >>> hw/area_ctrl_pkg.sv
// Package: map, register offsets, field layouts and reset values of the memory area control
package area_ctrl_pkg;
    localparam logic [23:0] FLASH_BASE = 24'h008000;
    localparam logic [23:0] FLASH_LAST = 24'h00ffff;
    localparam logic [23:0] RAM_LAST = 24'h0007ff;
    localparam logic [23:0] DBG_RAM_BASE = 24'h0007c0;
    localparam logic [23:0] DEBUG_BASE_HIGH = 24'hfffc00;
    localparam logic [23:0] DEBUG_BASE_LOW = 24'h000000;
    localparam logic [15:0] VECTOR_BASE_RESET = 16'h8000;
    localparam logic [15:0] ADDR_RAM_SIZE_CONTROL = 16'h5326;
    localparam logic [15:0] ADDR_FLASH_READ_WAIT = 16'h54b0;
    localparam logic [15:0] ADDR_WRITE_PROTECT = 16'hfffc;
    localparam logic [15:0] ADDR_READ_PROTECT = 16'hfffe;
    localparam logic [15:0] ADDR_PROTECTION_KEY = 16'h5320;
    localparam logic [15:0] ADDR_VECTOR_BASE_LOW = 16'h5328;
    localparam logic [15:0] ADDR_VECTOR_BASE_HIGH = 16'h532a;
    localparam logic [15:0] ADDR_AREA_STATUS = 16'h532c;
    localparam logic [7:0] UNLOCK_KEY = 8'h96;
    localparam logic [1:0] READ_WAIT_RESET = 2'h3;
    localparam logic [2:0] RAM_SEL_512 = 3'h5;
    localparam logic [2:0] RAM_SEL_1K = 3'h4;
    localparam logic [2:0] RAM_SEL_2K = 3'h3;
    localparam logic [2:0] RAM_SIZE_RESET = 3'h3;
    localparam logic [2:0] RAM_ACTUAL_SIZE = 3'h3;
    localparam logic [23:0] RAM_LAST_512 = 24'h0001ff;
    localparam logic [23:0] RAM_LAST_1K = 24'h0003ff;
    localparam int RAM_SEL_LSB = 0;
    localparam int RAM_ACT_LSB = 4;
    localparam int DBG_SEL_BIT = 8;
    localparam logic [7:0] PROTECT_RESET = 8'hff;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam int AREA_SHIFT = 12;
    localparam int SECTORS = 8;

    typedef struct packed {
        logic req;
        logic write;
        logic fetch;
        logic [23:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic ready;
        logic [15:0] rdata;
        logic error;
    } mem_rsp_t;

    typedef struct packed {
        logic wr_en;
        logic erase;
        logic [14:0] addr;
        logic [15:0] wdata;
    } flash_cmd_t;
endpackage

// >>> hw/flash_ram_area_control.sv
// Flash and RAM area control: decode, protection, read waits and control registers
`timescale 1ns/100ps
import area_ctrl_pkg::*;
module flash_ram_area_control (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    input wire area_ctrl_pkg::mem_req_t mem_req_in,
    output area_ctrl_pkg::mem_rsp_t mem_rsp_out,
    input wire logic [15:0] flash_rdata_in,
    input wire logic [15:0] ram_rdata_in,
    input wire logic debug_prog_in,
    input wire logic debug_erase_in,
    input wire logic debug_active_in,
    output area_ctrl_pkg::flash_cmd_t flash_cmd_out,
    output logic ram_we_out,
    output logic [10:0] ram_addr_out,
    output logic [15:0] ram_wdata_out,
    output logic [23:0] vector_base_out,
    output logic [23:0] debug_base_out
);
    import area_ctrl_pkg::*;

    typedef enum {ST_IDLE, ST_WAIT} acc_state_t;

    logic [7:0] protection_key;
    logic [1:0] read_wait_count;
    logic [2:0] ram_size_select;
    logic debug_base_select;
    logic [15:0] vector_base_low;
    logic [7:0] vector_base_high;
    logic [7:0] write_protect;
    logic [7:0] read_protect;
    logic [23:0] ram_limit;
    logic [7:0] blocked_count;
    acc_state_t state;
    logic [15:0] held_rdata;
    logic wait_busy;
    logic wait_done;
    logic in_flash;
    logic in_ram;
    logic [2:0] sector;
    logic wp_hit;
    logic rp_hit;
    logic ram_ok;
    logic key_open;
    logic flash_rd;
    logic [15:0] next_rdata;
    logic take;

    assign in_flash = mem_req_in.addr >= FLASH_BASE && mem_req_in.addr <= FLASH_LAST;
    assign in_ram = mem_req_in.addr <= RAM_LAST;
    assign sector = mem_req_in.addr[AREA_SHIFT+2:AREA_SHIFT];
    assign wp_hit = !write_protect[sector] && sector != 3'h7;
    assign rp_hit = !read_protect[sector] && sector != 3'h0 && !mem_req_in.fetch;
    assign ram_ok = in_ram && mem_req_in.addr <= ram_limit;
    assign key_open = protection_key == UNLOCK_KEY;
    assign flash_rd = mem_req_in.req && !mem_req_in.write && in_flash;
    assign take = mem_req_in.req && state == ST_IDLE && !mem_rsp_out.ready;

    // Usable RAM top from size select
    always_comb begin
        case (ram_size_select)
            RAM_SEL_512: ram_limit = RAM_LAST_512;
            RAM_SEL_1K: ram_limit = RAM_LAST_1K;
            default: ram_limit = RAM_LAST;
        endcase
    end

    wait_counter u_wait (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(take && flash_rd),
        .waits_in(read_wait_count),
        .busy_out(wait_busy),
        .done_out(wait_done)
    );

    // Access sequencer: one clock, plus waits on flash reads
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take && flash_rd && read_wait_count != 2'h0) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Read data selection with protection masking
    always_comb begin
        next_rdata = READ_ZERO;
        if (in_flash) begin
            next_rdata = rp_hit ? READ_ZERO : flash_rdata_in;
        end else if (ram_ok) begin
            next_rdata = ram_rdata_in;
        end
    end

    // Bus answer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_rsp_out <= '0;
            held_rdata <= READ_ZERO;
        end else begin
            mem_rsp_out.ready <= 1'b0;
            mem_rsp_out.error <= 1'b0;
            if (state == ST_WAIT) begin
                if (wait_done) begin
                    mem_rsp_out.ready <= 1'b1;
                    mem_rsp_out.rdata <= held_rdata;
                end
            end else if (take) begin
                held_rdata <= next_rdata;
                if (!(flash_rd && read_wait_count != 2'h0)) begin
                    mem_rsp_out.ready <= 1'b1;
                    mem_rsp_out.rdata <= mem_req_in.write ? READ_ZERO : next_rdata;
                    mem_rsp_out.error <= !(in_flash || ram_ok) || (mem_req_in.write && in_flash && wp_hit);
                end
            end
        end
    end

    // Flash write path, blocked in protected areas
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flash_cmd_out <= '0;
        end else begin
            flash_cmd_out.wr_en <= take && mem_req_in.write && in_flash && !wp_hit;
            flash_cmd_out.erase <= debug_erase_in && in_flash && !wp_hit;
            flash_cmd_out.addr <= mem_req_in.addr[14:0];
            flash_cmd_out.wdata <= mem_req_in.wdata;
        end
    end

    // RAM write path within the selected size
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ram_we_out <= 1'b0;
            ram_addr_out <= 11'h000;
            ram_wdata_out <= 16'h0000;
        end else begin
            ram_we_out <= take && mem_req_in.write && ram_ok;
            ram_addr_out <= mem_req_in.addr[10:0];
            ram_wdata_out <= mem_req_in.wdata;
        end
    end

    // Protect words: cleared bits only set back by the debugger
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_protect <= PROTECT_RESET;
            read_protect <= PROTECT_RESET;
        end else if (reg_write_in && reg_addr_in == ADDR_WRITE_PROTECT) begin
            if (debug_prog_in) begin
                write_protect <= reg_wdata_in[7:0];
            end else begin
                write_protect <= write_protect & reg_wdata_in[7:0];
            end
        end else if (reg_write_in && reg_addr_in == ADDR_READ_PROTECT) begin
            if (debug_prog_in) begin
                read_protect <= reg_wdata_in[7:0];
            end else begin
                read_protect <= read_protect & reg_wdata_in[7:0];
            end
        end
    end

    // Key, wait, RAM size and vector base registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            protection_key <= 8'h00;
            read_wait_count <= READ_WAIT_RESET;
            ram_size_select <= RAM_SIZE_RESET;
            debug_base_select <= 1'b0;
            vector_base_low <= VECTOR_BASE_RESET;
            vector_base_high <= 8'h00;
        end else if (reg_write_in) begin
            case (reg_addr_in)
                ADDR_PROTECTION_KEY: protection_key <= reg_wdata_in[7:0];
                ADDR_FLASH_READ_WAIT: read_wait_count <= reg_wdata_in[1:0];
                ADDR_RAM_SIZE_CONTROL: begin
                    if (key_open) begin
                        ram_size_select <= reg_wdata_in[RAM_SEL_LSB+2:RAM_SEL_LSB];
                        debug_base_select <= reg_wdata_in[DBG_SEL_BIT];
                    end
                end
                ADDR_VECTOR_BASE_LOW: vector_base_low <= reg_wdata_in;
                ADDR_VECTOR_BASE_HIGH: vector_base_high <= reg_wdata_in[7:0];
                default: protection_key <= protection_key;
            endcase
        end
    end

    // Count of refused accesses for status
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            blocked_count <= 8'h00;
        end else if (take && blocked_count != 8'hff) begin
            if ((mem_req_in.write && in_flash && wp_hit) || (!mem_req_in.write && in_flash && rp_hit)) begin
                blocked_count <= blocked_count + 8'h01;
            end
        end
    end

    // Derived outputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vector_base_out <= {8'h00, VECTOR_BASE_RESET};
            debug_base_out <= DEBUG_BASE_HIGH;
        end else begin
            vector_base_out <= {vector_base_high, vector_base_low};
            debug_base_out <= debug_base_select ? DEBUG_BASE_LOW : DEBUG_BASE_HIGH;
        end
    end

    // Register read port, data one cycle after strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                ADDR_FLASH_READ_WAIT: reg_rdata_out <= {14'h0000, read_wait_count};
                ADDR_RAM_SIZE_CONTROL: reg_rdata_out <= {7'h00, debug_base_select, 1'b0, RAM_ACTUAL_SIZE, 1'b0,
                    ram_size_select};
                ADDR_WRITE_PROTECT: reg_rdata_out <= {8'h00, write_protect};
                ADDR_READ_PROTECT: reg_rdata_out <= {8'h00, read_protect};
                ADDR_PROTECTION_KEY: reg_rdata_out <= {8'h00, protection_key};
                ADDR_VECTOR_BASE_LOW: reg_rdata_out <= vector_base_low;
                ADDR_VECTOR_BASE_HIGH: reg_rdata_out <= {8'h00, vector_base_high};
                ADDR_AREA_STATUS: reg_rdata_out <= {5'h00, wait_busy, debug_active_in, state == ST_WAIT,
                    blocked_count};
                default: reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    property p_wait_reset;
        @(posedge clk_in) $rose(rst_n_in) |-> read_wait_count == READ_WAIT_RESET;
    endproperty
    a_wait_reset: assert property (p_wait_reset) else $error("wait field not 3 after reset");

    property p_key_guard;
        @(posedge clk_in) disable iff (!rst_n_in)
            reg_write_in && reg_addr_in == ADDR_RAM_SIZE_CONTROL && !key_open |=> $stable(ram_size_select);
    endproperty
    a_key_guard: assert property (p_key_guard) else $error("size select changed while locked");

    property p_wp_block;
        @(posedge clk_in) disable iff (!rst_n_in)
            mem_req_in.req && mem_req_in.write && in_flash && wp_hit |=> !flash_cmd_out.wr_en;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("write reached protected area");

    property p_rp_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
            take && flash_rd && rp_hit && read_wait_count == 2'h0 |=> mem_rsp_out.rdata == READ_ZERO;
    endproperty
    a_rp_zero: assert property (p_rp_zero) else $error("protected read returned data");

    property p_no_wait;
        @(posedge clk_in) disable iff (!rst_n_in)
            take && !flash_rd |=> mem_rsp_out.ready;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("access took more than one clock");

    property p_three_waits;
        @(posedge clk_in) disable iff (!rst_n_in)
            take && flash_rd && read_wait_count == 2'h3 |=> !mem_rsp_out.ready [*3] ##1 mem_rsp_out.ready;
    endproperty
    a_three_waits: assert property (p_three_waits) else $error("wait count not honoured");

    property p_protect_sticky;
        @(posedge clk_in) disable iff (!rst_n_in)
            !debug_prog_in |=> (write_protect & ~$past(write_protect)) == 8'h00;
    endproperty
    a_protect_sticky: assert property (p_protect_sticky) else $error("protection removed by software");

    property p_ram_limit;
        @(posedge clk_in) disable iff (!rst_n_in)
            mem_req_in.req && mem_req_in.write && ram_size_select == RAM_SEL_512 &&
            mem_req_in.addr > RAM_LAST_512 |=> !ram_we_out;
    endproperty
    a_ram_limit: assert property (p_ram_limit) else $error("write beyond selected RAM size");

    property p_debug_base;
        @(posedge clk_in) disable iff (!rst_n_in)
            debug_base_select |=> debug_base_out == DEBUG_BASE_LOW;
    endproperty
    a_debug_base: assert property (p_debug_base) else $error("debug base mismatch");

    property p_rp_sticky;
        @(posedge clk_in) disable iff (!rst_n_in)
            !debug_prog_in |=> (read_protect & ~$past(read_protect)) == 8'h00;
    endproperty
    a_rp_sticky: assert property (p_rp_sticky) else $error("read protection removed by software");

    property p_erase_block;
        @(posedge clk_in) disable iff (!rst_n_in)
            debug_erase_in && in_flash && wp_hit |=> !flash_cmd_out.erase;
    endproperty
    a_erase_block: assert property (p_erase_block) else $error("erase reached protected area");

    property p_actual_size;
        @(posedge clk_in) disable iff (!rst_n_in)
            reg_read_in && reg_addr_in == ADDR_RAM_SIZE_CONTROL |=> reg_rdata_out[6:4] == RAM_ACTUAL_SIZE;
    endproperty
    a_actual_size: assert property (p_actual_size) else $error("actual size field wrong");
endmodule

// >>> hw/wait_counter.sv
// Flash read wait cycle counter
`timescale 1ns/100ps
module wait_counter (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [1:0] waits_in,
    output logic busy_out,
    output logic done_out
);
    logic [1:0] remain;

    // Each configured wait stalls the access for one clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            remain <= 2'h0;
            busy_out <= 1'b0;
        end else if (start_in && !busy_out && waits_in != 2'h0) begin
            remain <= waits_in - 2'h1;
            busy_out <= 1'b1;
        end else if (busy_out) begin
            if (remain == 2'h0) begin
                busy_out <= 1'b0;
            end else begin
                remain <= remain - 2'h1;
            end
        end
    end

    assign done_out = busy_out && remain == 2'h0;
endmodule

// >>> test/flash_ram_area_control_tb.sv
// Testbench for the flash and RAM area control
`timescale 1ns/100ps
module flash_ram_area_control_tb;
    import area_ctrl_pkg::*;
    logic clk_in, rst_n_in, reg_write, reg_read, dbg_prog, dbg_erase, dbg_active, ram_we, err;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, frd, rrd, ram_wdata, d;
    logic [10:0] ram_addr;
    logic [23:0] vbase, dbase;
    mem_req_t mreq;
    mem_rsp_t mrsp;
    flash_cmd_t fcmd;
    int fails, total_checks, wr_pulses, n, p;

    flash_ram_area_control i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
        .reg_rdata_out(reg_rdata), .mem_req_in(mreq), .mem_rsp_out(mrsp), .flash_rdata_in(frd),
        .ram_rdata_in(rrd), .debug_prog_in(dbg_prog), .debug_erase_in(dbg_erase), .debug_active_in(dbg_active),
        .flash_cmd_out(fcmd), .ram_we_out(ram_we), .ram_addr_out(ram_addr), .ram_wdata_out(ram_wdata),
        .vector_base_out(vbase), .debug_base_out(dbase));

    mem_array_model i_mem (.clk_in(clk_in), .addr_in(mreq.addr), .ram_we_in(ram_we),
        .ram_addr_in(ram_addr), .ram_wdata_in(ram_wdata), .flash_rdata_out(frd), .ram_rdata_out(rrd));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (fcmd.wr_en === 1'b1) wr_pulses++;
    end

    function automatic logic [15:0] pat(input logic [23:0] a);
        return a[15:0] ^ 16'h3c5a;
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk_in);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_in);
        reg_write <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_in);
        reg_read <= 1'b0;
        @(posedge clk_in);
        check(24'(reg_rdata), 24'(exp));
    endtask

    // Holds the request until ready is sampled, n counts edges from launch
    task automatic acc(input logic w, input logic f, input logic [23:0] a, input logic [15:0] v);
        @(posedge clk_in);
        mreq <= mem_req_t'{req: 1'b1, write: w, fetch: f, addr: a, wdata: v};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (mrsp.ready !== 1'b1 && n < 20);
        check(24'(mrsp.ready), 24'h1);
        d = mrsp.rdata;
        err = mrsp.error;
        mreq.req <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask

    // One erase pulse at an address, then the erase command is compared
    task automatic erase_chk(input logic [23:0] a, input logic exp);
        @(posedge clk_in);
        mreq.addr <= a;
        dbg_erase <= 1'b1;
        @(posedge clk_in);
        dbg_erase <= 1'b0;
        @(posedge clk_in);
        check(24'(fcmd.erase), 24'(exp));
    endtask

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        finish_test;
    end

    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        dbg_prog = 1'b0;
        dbg_erase = 1'b0;
        dbg_active = 1'b0;
        mreq = '0;
        fails = 0;
        total_checks = 0;
        wr_pulses = 0;
        rst_n_in = 1'b0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        check(vbase, 24'h008000);
        check(dbase, 24'hfffc00);
        rchk(ADDR_FLASH_READ_WAIT, 16'h0003);
        rchk(ADDR_RAM_SIZE_CONTROL, 16'h0033);
        rchk(ADDR_WRITE_PROTECT, 16'h00ff);
        rchk(ADDR_READ_PROTECT, 16'h00ff);
        rchk(16'h5400, 16'h0000);
        // Each wait setting, ending at zero waits
        for (int w = 3; w >= 0; w--) begin
            wr(ADDR_FLASH_READ_WAIT, 16'hfffc | 16'(w));
            rchk(ADDR_FLASH_READ_WAIT, 16'(w));
            acc(1'b0, 1'b0, 24'h00c000 + 24'(w * 2), 16'h0000);
            check(24'(n), 24'(w + 2));
            check(24'(d), 24'(pat(24'h00c000 + 24'(w * 2))));
        end
        // RAM, including the debugger tail when not debugging
        acc(1'b1, 1'b0, 24'h0007c2, 16'hbeef);
        check(24'(err), 24'h0);
        acc(1'b0, 1'b0, 24'h0007c2, 16'h0000);
        check(24'(n), 24'h2);
        check(24'(d), 24'h00beef);
        acc(1'b0, 1'b0, 24'h000800, 16'h0000);
        check(24'(err), 24'h1);
        // Size register, locked then unlocked
        wr(ADDR_RAM_SIZE_CONTROL, 16'h0105);
        rchk(ADDR_RAM_SIZE_CONTROL, 16'h0033);
        wr(ADDR_PROTECTION_KEY, 16'h0096);
        wr(ADDR_RAM_SIZE_CONTROL, 16'hff05);
        wr(ADDR_PROTECTION_KEY, 16'h0000);
        rchk(ADDR_RAM_SIZE_CONTROL, 16'h0135);
        check(dbase, 24'h000000);
        acc(1'b0, 1'b0, 24'h000200, 16'h0000);
        check(24'(err), 24'h1);
        acc(1'b0, 1'b0, 24'h0001fe, 16'h0000);
        check(24'(err), 24'h0);
        // Write protection of the 0x9000 area
        wr(ADDR_WRITE_PROTECT, 16'hfffd);
        rchk(ADDR_WRITE_PROTECT, 16'h00fd);
        p = wr_pulses;
        acc(1'b1, 1'b0, 24'h009000, 16'h1111);
        check(24'(err), 24'h1);
        check(24'(wr_pulses), 24'(p));
        acc(1'b1, 1'b0, 24'h00a000, 16'h2222);
        check(24'(err), 24'h0);
        check(24'(wr_pulses > p), 24'h1);
        check(24'(fcmd.addr), 24'h002000);
        check(24'(fcmd.wdata), 24'h002222);
        // Erase blocked in a protected area, protect word sector stays erasable
        wr(ADDR_WRITE_PROTECT, 16'h007f);
        erase_chk(24'h009000, 1'b0);
        erase_chk(24'h00f000, 1'b1);
        wr(ADDR_WRITE_PROTECT, 16'h00ff);
        rchk(ADDR_WRITE_PROTECT, 16'h007d);
        @(posedge clk_in);
        dbg_prog <= 1'b1;
        wr(ADDR_WRITE_PROTECT, 16'h00ff);
        @(posedge clk_in);
        dbg_prog <= 1'b0;
        rchk(ADDR_WRITE_PROTECT, 16'h00ff);
        // Read protection of the 0xa000 area, D0 left at one
        wr(ADDR_READ_PROTECT, 16'h00fb);
        acc(1'b0, 1'b0, 24'h00a010, 16'h0000);
        check(24'(d), 24'h0);
        acc(1'b0, 1'b1, 24'h00a010, 16'h0000);
        check(24'(d), 24'(pat(24'h00a010)));
        acc(1'b0, 1'b0, 24'h00b010, 16'h0000);
        check(24'(d), 24'(pat(24'h00b010)));
        // Vector base relocation
        wr(ADDR_VECTOR_BASE_LOW, 16'h1234);
        wr(ADDR_VECTOR_BASE_HIGH, 16'h0056);
        @(posedge clk_in);
        @(posedge clk_in);
        check(vbase, 24'h561234);
        // Status: debugger flag and two refused accesses
        dbg_active <= 1'b1;
        rchk(ADDR_AREA_STATUS, 16'h0202);
        finish_test;
    end
endmodule

// >>> test/mem_array_model.sv
// Model of the flash and RAM arrays behind the area control
`timescale 1ns/100ps
module mem_array_model (
    input wire logic clk_in,
    input wire logic [23:0] addr_in,
    input wire logic ram_we_in,
    input wire logic [10:0] ram_addr_in,
    input wire logic [15:0] ram_wdata_in,
    output logic [15:0] flash_rdata_out,
    output logic [15:0] ram_rdata_out
);
    logic [15:0] ram [0:1023];

    // Flash content pattern, distinct per word
    assign flash_rdata_out = addr_in[15:0] ^ 16'h3c5a;
    // RAM read for the current request address
    assign ram_rdata_out = ram[addr_in[10:1]];

    always_ff @(posedge clk_in) begin
        if (ram_we_in) begin
            ram[ram_addr_in[10:1]] <= ram_wdata_in;
        end
    end
endmodule
